// *** pdac_host_pkg.sv ***
// Package of constants for the parallel converter host controller.
// Assumes a 100 MHz ref_clk and an AXI4-Lite master on the software side.
//
// Function
// [R1] Device captures bus code on chip select rise.
// [R2] Write cycle loads input register only.
// [R3] Low load strobe copies input to converter.
// [R4] Code is one parallel 16-bit word.
// [R5] Clear forces min- or mid-scale code.
// [R6] Clear is asynchronous, low-active, select-chosen.
// [R7] Low reference enable turns reference on.
// [R8] Read data valid 100 ns after select.
// [R9] Bus released within 70 ns after read.
// [R10] Write: setup/hold 10 ns, select 25 ns.
// [R11] Read: setup/hold 10 ns, select 90 ns.
// [R12] Write data stable until 20 ns after.
// [R13] Clear low 30 ns, select held 10 ns.
// [R14] Direct update: load low 20 ns, 30 ns.
// [R15] Shared load strobe updates many devices together.
// [R16] Select high mid-scale, low min-scale.
// [R17] Clear also loads the input register.
// [R18] Read drives input register onto bus.
// [R19] Load low during write gives transparency.
// [R20] Device drives bus only during reads.
// [R21] Idle strobes keep both registers unchanged.
package pdac_host_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // Period of ref_clk.
  localparam int T_SETUP_NS    = 10;  // Direction setup and hold around select.
  localparam int T_WCS_NS      = 25;  // Select low for a write.
  localparam int T_RCS_NS      = 90;  // Select low for a read.
  localparam int T_CSD_NS      = 100; // Select low to read data valid.
  localparam int T_DZ_NS       = 70;  // Select high to bus released.
  localparam int T_DH_NS       = 20;  // Write data hold after select high.
  localparam int T_RSS_NS      = 30;  // Clear low width.
  localparam int T_SH_NS       = 10;  // Clear-select hold after clear high.
  localparam int T_LWD_NS      = 20;  // Load strobe low width.
  localparam int T_LS_NS       = 30;  // Select low to load high, direct update.

  // Least times round up to whole cycles.
  localparam int C_SETUP = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_WCS   = (T_WCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_RCS   = (T_RCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_CSD   = (T_CSD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DZ    = (T_DZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_DH    = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_RSS   = (T_RSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_SH    = (T_SH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_LWD   = (T_LWD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_LS    = (T_LS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Codes and register map
  // ----------------------------------------------------------------
  localparam int          CODE_W    = 16;
  localparam logic [15:0] CODE_MIN  = 16'hFFFF; // Min-scale clear code.
  localparam logic [15:0] CODE_MID  = 16'h7FFF; // Mid-scale clear code.

  localparam logic [3:0] OFS_CTRL   = 4'h0; // Command and pin levels.
  localparam logic [3:0] OFS_WDATA  = 4'h4; // Code to write.
  localparam logic [3:0] OFS_RDATA  = 4'h8; // Code read back.
  localparam logic [3:0] OFS_STATUS = 4'hC; // Busy and done.

  // Control and status register fields.
  localparam int CTRL_START  = 0; // Write 1 to start the command.
  localparam int CTRL_CMD_LO = 1; // Command field, bits 3:1.
  localparam int CTRL_CMD_HI = 3;
  localparam int CTRL_SEL    = 4; // Clear-select level (1 mid-scale).
  localparam int CTRL_REFOFF = 5; // 1 disables the internal reference.
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Commands the sequencer carries out.
  typedef enum logic [2:0] {
    CMD_WRITE  = 3'b000, // Write input register only.
    CMD_READ   = 3'b001, // Read input register back.
    CMD_LOAD   = 3'b010, // Pulse the load strobe alone.
    CMD_DIRECT = 3'b011, // Write with load strobe low (transparent).
    CMD_CLEAR  = 3'b100  // Pulse clear.
  } cmd_e;

endpackage

// *** pdac_cmd_if.sv ***
// Interface carrying one command from the register slave to the pin sequencer.
// Assumes both ends run on ref_clk.
interface pdac_cmd_if;
  import pdac_host_pkg::*;
  logic        start;    // One-cycle pulse: begin a command.
  cmd_e        cmd;      // Command to run.
  logic [15:0] wrCode;   // Code for writes.
  logic        sel;      // Clear-select level.
  logic        busy;     // Sequencer busy.
  logic        done;     // One-cycle pulse at end.
  logic [15:0] rdCode;   // Code captured on read.

  modport master (output start, cmd, wrCode, sel, input busy, done, rdCode);
  modport seq    (input start, cmd, wrCode, sel, output busy, done, rdCode);
endinterface

// *** pdac_pin_seq.sv ***
// Pin sequencer: turns one command into timed strobes on the converter pins.
// Assumes the read-back bus is already synchronised by the caller.
module pdac_pin_seq
  import pdac_host_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Command side
  pdac_cmd_if.seq          cmdPort,
  // Synchronised read data
  input  wire logic [15:0] busInSync,
  // Pins
  output logic             chipSelN,
  output logic             readWriteN,
  output logic             loadOutputStrobeN,
  output logic             clearN,
  output logic             clearLevelSelect,
  output logic [15:0]      busOut,
  output logic             busOe
);
  import pdac_host_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000, // Strobes high, bus floating.
    ST_SETUP = 3'b001, // Direction and data settle before select.
    ST_LOW   = 3'b010, // Select (or load, or clear) held low.
    ST_HOLD  = 3'b011, // Direction and data held after release.
    ST_DONE  = 3'b100  // Report completion.
  } state_e;

  typedef struct packed {
    state_e      st;
    logic [7:0]  cnt;
    cmd_e        cmd;
    logic        csN;
    logic        rwN;
    logic        ldN;
    logic        clrN;
    logic        sel;
    logic [15:0] dout;
    logic        oe;
    logic [15:0] rd;
    logic        done;
  } seq_s;

  seq_s q, d;

  // Low time for the active strobe of each command.
  function automatic logic [7:0] lowCycles(input cmd_e c);
    unique case (c)
      CMD_WRITE:  lowCycles = 8'(C_WCS);                       // [R10]
      // A read also waits out the two synchroniser stages plus one edge of margin.
      CMD_READ:   lowCycles = 8'(((C_RCS > C_CSD) ? C_RCS : C_CSD) + 3); // [R8] [R11]
      CMD_LOAD:   lowCycles = 8'(C_LWD);                       // [R14]
      CMD_DIRECT: lowCycles = 8'((C_LS > C_WCS) ? C_LS : C_WCS); // [R14]
      CMD_CLEAR:  lowCycles = 8'(C_RSS);                       // [R13]
      default:    lowCycles = 8'd1;
    endcase
  endfunction

  // Hold time after release; a read waits out the bus release.
  function automatic logic [7:0] holdCycles(input cmd_e c);
    unique case (c)
      CMD_READ:  holdCycles = 8'((C_DZ > C_SETUP) ? C_DZ : C_SETUP); // [R9]
      CMD_CLEAR: holdCycles = 8'(C_SH);                              // [R13]
      CMD_LOAD:  holdCycles = 8'd1;
      default:   holdCycles = 8'((C_DH > C_SETUP) ? C_DH : C_SETUP); // [R12]
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (cmdPort.start) begin
          d.cmd = cmdPort.cmd;
          d.cnt = 8'(C_SETUP);
          d.st  = ST_SETUP;
          // Direction set before select falls.
          d.rwN = (cmdPort.cmd == CMD_READ);                 // [R10] [R11]
          d.dout = cmdPort.wrCode;                           // [R4] [R12]
          d.oe  = (cmdPort.cmd == CMD_WRITE) || (cmdPort.cmd == CMD_DIRECT);
          d.sel = cmdPort.sel;                               // [R13] [R16]
        end
      end
      ST_SETUP: begin
        if (q.cnt > 8'd1) begin
          d.cnt = q.cnt - 8'd1;
        end else begin
          d.cnt = lowCycles(q.cmd);
          d.st  = ST_LOW;
          unique case (q.cmd)
            CMD_LOAD:   d.ldN  = 1'b0;                       // [R3] [R15]
            CMD_CLEAR:  d.clrN = 1'b0;                       // [R5] [R6]
            CMD_DIRECT: begin
              d.csN = 1'b0;
              d.ldN = 1'b0;                                  // [R19]
            end
            default:    d.csN = 1'b0;                        // [R2] [R18]
          endcase
        end
      end
      ST_LOW: begin
        if (q.cnt > 8'd1) begin
          d.cnt = q.cnt - 8'd1;
        end else begin
          // Read data has settled by now; sample before select rises.
          if (q.cmd == CMD_READ) begin
            d.rd = busInSync;                                // [R8]
          end
          d.csN  = 1'b1;                                     // [R1]
          d.ldN  = 1'b1;
          d.clrN = 1'b1;
          d.cnt  = holdCycles(q.cmd);
          d.st   = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (q.cnt > 8'd1) begin
          d.cnt = q.cnt - 8'd1;
        end else begin
          d.oe  = 1'b0;
          d.rwN = 1'b1;
          d.st  = ST_DONE;
        end
      end
      ST_DONE: begin
        d.done = 1'b1;
        d.st   = ST_IDLE;
      end
      default: d.st = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: ST_IDLE, cnt: 8'd0, cmd: CMD_WRITE, csN: 1'b1, rwN: 1'b1,
             ldN: 1'b1, clrN: 1'b1, sel: 1'b0, dout: 16'h0000, oe: 1'b0,
             rd: 16'h0000, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Pin outputs straight from the state flops; busy is decoded from the state; idle strobes leave registers alone.
  assign chipSelN          = q.csN;  // [R21]
  assign readWriteN        = q.rwN;
  assign loadOutputStrobeN = q.ldN;
  assign clearN            = q.clrN;
  assign clearLevelSelect  = q.sel;
  assign busOut            = q.dout;
  assign busOe             = q.oe;   // [R20]
  assign cmdPort.busy      = (q.st != ST_IDLE);
  assign cmdPort.done      = q.done;
  assign cmdPort.rdCode    = q.rd;

endmodule

// *** pdac_host_ctrl.sv ***
// Top of the host controller: AXI4-Lite slave registers plus pin sequencer.
// Assumes the converter pins are wired directly; bus input is asynchronous.
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
module pdac_host_ctrl
  import pdac_host_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter pins
  output logic             chipSelN,
  output logic             readWriteN,
  output logic             loadOutputStrobeN,
  output logic             clearN,
  output logic             clearLevelSelect,
  output logic             internalRefEnableN,
  input  wire logic [15:0] parallelDataBusIn,
  output logic [15:0]      parallelDataBusOut,
  output logic             parallelDataBusOe
);
  import pdac_host_pkg::*;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awr;     // Write address held.
    logic [3:0]  awa;
    logic        wr;      // Write data held.
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [31:0] ctrl;
    logic [15:0] code;
    logic        start;
    logic        done;    // Sticky completion flag.
    logic [15:0] sync1;   // Synchroniser stage one.
    logic [15:0] sync2;   // Synchroniser stage two.
    logic        awRdy;   // Registered write-address ready.
    logic        wRdy;    // Registered write-data ready.
    logic        arRdy;   // Registered read-address ready.
  } top_s;

  top_s q, d;
  pdac_cmd_if cmdBus();

  // Byte-strobe merge; a control write still lands while a command runs, only its start is ignored.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    d.start = 1'b0;
    d.sync1 = parallelDataBusIn;
    d.sync2 = q.sync1;
    // Accept address and data independently, one write at a time.
    if (s_axi_awvalid && !q.awr && !q.bv) begin
      d.awr = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.wr && !q.bv) begin
      d.wr = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.awr && q.wr) begin
      d.awr = 1'b0;
      d.wr  = 1'b0;
      d.bv  = 1'b1;
      d.br  = RESP_OKAY;
      unique case (q.awa)
        OFS_CTRL: begin
          d.ctrl = merge(q.ctrl, q.wd, q.ws);
          d.ctrl[CTRL_START] = 1'b0;
          if (q.ws[0] && q.wd[CTRL_START] && !cmdBus.busy) begin
            d.start = 1'b1;
          end
        end
        OFS_WDATA:  d.code = 16'(merge({16'h0000, q.code}, q.wd, q.ws));
        OFS_STATUS: if (q.ws[0] && q.wd[STAT_DONE]) d.done = 1'b0;
        OFS_RDATA:  d.br = RESP_OKAY;
        default:    d.br = RESP_SLVERR;
      endcase
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    // Completion sets the flag; set wins over a same-cycle clear.
    if (cmdBus.done) begin
      d.done = 1'b1;
    end
    if (s_axi_arvalid && !q.rv) begin
      d.rv = 1'b1;
      d.rr = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CTRL:   d.rd = q.ctrl;
        OFS_WDATA:  d.rd = {16'h0000, q.code};
        OFS_RDATA:  d.rd = {16'h0000, cmdBus.rdCode};
        OFS_STATUS: d.rd = {30'h0, q.done, cmdBus.busy};
        default: begin
          d.rd = 32'h0000_0000;
          d.rr = RESP_SLVERR;
        end
      endcase
    end else if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
    end
    // Readies are flops that mirror the next holding state, so no output is gated.
    d.awRdy = !d.awr && !d.bv;
    d.wRdy  = !d.wr && !d.bv;
    d.arRdy = !d.rv;
  end

  // Register state.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{awr: 1'b0, awa: 4'h0, wr: 1'b0, wd: 32'h0, ws: 4'h0, bv: 1'b0,
             br: 2'b00, rv: 1'b0, rd: 32'h0, rr: 2'b00, ctrl: CTRL_RESET,
             code: 16'h0000, start: 1'b0, done: 1'b0, sync1: 16'h0000,
             sync2: 16'h0000, awRdy: 1'b1, wRdy: 1'b1, arRdy: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready      = q.awRdy;
  assign s_axi_wready       = q.wRdy;
  assign s_axi_bvalid       = q.bv;
  assign s_axi_bresp        = q.br;
  assign s_axi_arready      = q.arRdy;
  assign s_axi_rvalid       = q.rv;
  assign s_axi_rdata        = q.rd;
  assign s_axi_rresp        = q.rr;
  assign internalRefEnableN = q.ctrl[CTRL_REFOFF]; // [R7]

  assign cmdBus.start  = q.start;
  assign cmdBus.cmd    = cmd_e'(q.ctrl[CTRL_CMD_HI:CTRL_CMD_LO]);
  assign cmdBus.wrCode = q.code;
  assign cmdBus.sel    = q.ctrl[CTRL_SEL];

  // Pin sequencer.
  pdac_pin_seq uSeq (
    .ref_clk           (ref_clk),
    .arst_n            (arst_n),
    .cmdPort           (cmdBus),
    .busInSync         (q.sync2),
    .chipSelN          (chipSelN),
    .readWriteN        (readWriteN),
    .loadOutputStrobeN (loadOutputStrobeN),
    .clearN            (clearN),
    .clearLevelSelect  (clearLevelSelect),
    .busOut            (parallelDataBusOut),
    .busOe             (parallelDataBusOe)
  );

endmodule

// *** pdac_host_chk.sv ***
// Concurrent checks on the converter pins driven by the host controller.
// Assumes one 100 MHz ref_clk and the port names of pdac_host_ctrl.
module pdac_host_chk
  import pdac_host_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Converter pins
  input wire logic        chipSelN,
  input wire logic        readWriteN,
  input wire logic        loadOutputStrobeN,
  input wire logic        clearN,
  input wire logic        clearLevelSelect,
  input wire logic [15:0] parallelDataBusOut,
  input wire logic        parallelDataBusOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // ---------------------------------------------------------------
  // Select low-time counter
  // ---------------------------------------------------------------
  // A counter, because a nine-cycle repetition would be slow to unroll.
  logic [7:0] lowCnt_q;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) lowCnt_q <= 8'h00;
    else lowCnt_q <= chipSelN ? 8'h00 : lowCnt_q + 8'h01;
  end

  // ---------------------------------------------------------------
  // Pin timing
  // ---------------------------------------------------------------
  rw_setup_a: assert property ($fell(chipSelN) |-> $stable(readWriteN))
    else $error("direction moved with select fall");
  rw_hold_a: assert property ($rose(chipSelN) |=> $stable(readWriteN))
    else $error("direction moved right after select rise");
  wr_width_a: assert property ($fell(chipSelN) && !readWriteN |-> !chipSelN [*3])
    else $error("write select too short");
  rd_width_a: assert property ($rose(chipSelN) && readWriteN |-> lowCnt_q >= C_RCS)
    else $error("read select too short");
  wr_data_a: assert property (!chipSelN && !readWriteN
    |-> parallelDataBusOe && $stable(parallelDataBusOut))
    else $error("write data moved while selected");
  data_hold_a: assert property ($rose(chipSelN) && !readWriteN
    |-> (parallelDataBusOe && $stable(parallelDataBusOut)) [*2])
    else $error("write data released too early");
  clr_width_a: assert property ($fell(clearN) |-> !clearN [*3])
    else $error("clear pulse too short");
  clr_sel_a: assert property (!clearN || $rose(clearN) |-> $stable(clearLevelSelect))
    else $error("clear select moved during clear");
  ld_width_a: assert property ($fell(loadOutputStrobeN) |-> !loadOutputStrobeN [*2])
    else $error("load strobe too short");
  ld_release_a: assert property ($rose(loadOutputStrobeN) && !$past(chipSelN)
    |-> lowCnt_q >= C_LS)
    else $error("load released too soon after select");

  // Main transfers seen at least once.
  cover property ($rose(chipSelN) && !readWriteN);
  cover property ($rose(chipSelN) && readWriteN);
  cover property ($fell(clearN));
  cover property ($fell(loadOutputStrobeN) && !chipSelN);
endmodule

bind pdac_host_ctrl pdac_host_chk chk (
  .ref_clk(ref_clk), .arst_n(arst_n), .chipSelN(chipSelN), .readWriteN(readWriteN),
  .loadOutputStrobeN(loadOutputStrobeN), .clearN(clearN),
  .clearLevelSelect(clearLevelSelect), .parallelDataBusOut(parallelDataBusOut),
  .parallelDataBusOe(parallelDataBusOe));

// *** pdac_dev_model.sv ***
// Behavioural model of the parallel-bus converter's digital front end.
// Assumes pins arrive straight from the host; ref_clk only paces the idle bus.
module pdac_dev_model
  import pdac_host_pkg::*;
(
  // Idle-bus pacing and read speed
  input  wire logic        ref_clk,
  input  wire logic        slowRead,
  // Strobes
  input  wire logic        chipSelN,
  input  wire logic        readWriteN,
  input  wire logic        loadOutputStrobeN,
  input  wire logic        clearN,
  input  wire logic        clearLevelSelect,
  input  wire logic        internalRefEnableN,
  // Data bus
  input  wire logic [15:0] hostData,
  input  wire logic        hostOe,
  output logic      [15:0] busLevel,
  // Observed state
  output logic      [15:0] inCode,
  output logic      [15:0] dacCode,
  output logic             refOn,
  output logic             clash
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        devDrv;          // The device drives the bus.
  logic [15:0] floatPat = 16'h1357; // Undriven bus; changes each cycle, no pull on it.
  logic [15:0] clrCode;         // Code a clear forces.

  assign clrCode = clearLevelSelect ? CODE_MID : CODE_MIN;
  assign refOn = !internalRefEnableN;
  assign busLevel = hostOe ? hostData : (devDrv ? inCode : floatPat);
  assign clash = hostOe && devDrv;
  always @(posedge ref_clk) floatPat <= {floatPat[0], floatPat[15:1]} ^ 16'h3C5A;

  // Input register: follows the bus while a write is selected and keeps the last
  // word at select rise, so a load released with select still sees it.
  always @* begin
    if (!clearN) inCode = clrCode;
    else if (!chipSelN && !readWriteN) inCode = busLevel;
  end

  // Converter register; every other pin state holds it.
  always @* begin
    if (!clearN) dacCode = clrCode;
    else if (!loadOutputStrobeN && chipSelN) dacCode = inCode;
    else if (!loadOutputStrobeN && !readWriteN) dacCode = busLevel;
  end

  // Read drive: data appears late within the limit, released late too.
  always @(negedge chipSelN) if (readWriteN && clearN) begin
    #(slowRead ? 90 : 30);
    devDrv = !chipSelN;
  end
  always @(posedge chipSelN) if (devDrv) begin
    #(slowRead ? 70 : 10);
    devDrv = 1'b0;
  end
  initial devDrv = 1'b0;
endmodule

// *** parallel_dac_code_interface_tb.sv ***
// Self-checking bench: AXI4-Lite master, converter model, response monitor.
// Assumes pdac_host_ctrl, its package and the bound checker are compiled first.
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin nMismatch++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module parallel_dac_code_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pdac_host_pkg::*;
  logic        ref_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, slowRead;
  logic        csN, rwN, ldN, clrN, selLvl, refN, hostOe, clash, refOn;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [15:0] hostData, busLevel, inCode, dacCode;
  logic [34:0] rq[$];   // Read notes: check flag, response, data.
  logic [1:0]  bq[$];   // Write response notes.
  int          nMismatch, nCompared;

  pdac_host_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chipSelN(csN), .readWriteN(rwN), .loadOutputStrobeN(ldN), .clearN(clrN),
    .clearLevelSelect(selLvl), .internalRefEnableN(refN), .parallelDataBusIn(busLevel),
    .parallelDataBusOut(hostData), .parallelDataBusOe(hostOe));
  pdac_dev_model dev (.ref_clk(ref_clk), .slowRead(slowRead), .chipSelN(csN),
    .readWriteN(rwN), .loadOutputStrobeN(ldN), .clearN(clrN), .clearLevelSelect(selLvl),
    .internalRefEnableN(refN), .hostData(hostData), .hostOe(hostOe), .busLevel(busLevel),
    .inCode(inCode), .dacCode(dacCode), .refOn(refOn), .clash(clash));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // One write: address and data offered together, each dropped once taken.
  task automatic axWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bq.push_back(er);
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(posedge ref_clk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge ref_clk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // One read; the monitor judges it against the note pushed here.
  task automatic axRd(input logic [3:0] a, input logic chk, input logic [1:0] er,
                      input logic [31:0] ed, output logic [31:0] d);
    rq.push_back({chk, er, ed});
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask

  // Start a command and poll busy; a stuck sequencer is left to the watchdog.
  task automatic runCmd(input cmd_e c, input logic sel, input logic refOff);
    logic [31:0] s;
    axWr(OFS_CTRL, {26'h0, refOff, sel, c, 1'b1}, 2'b00);
    s = 32'h1;
    while (s[STAT_BUSY] !== 1'b0) axRd(OFS_STATUS, 1'b0, 2'b00, 32'h0, s);
  endtask

  task automatic closeOut();
    if (nMismatch == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Monitor: every response is matched to the oldest note.
  always @(posedge ref_clk) begin
    logic [34:0] e;
    logic [1:0]  eb;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = rq.pop_front();
      `CHK(rresp, e[33:32])
      if (e[34]) `CHK(rdata, e[31:0])
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      eb = bq.pop_front();
      `CHK(bresp, eb)
    end
    if (clash === 1'b1) `CHK(clash, 1'b0)
  end

  initial begin
    #100us;
    nMismatch++;
    closeOut();
  end

  initial begin
    logic [31:0] d;
    logic [15:0] c;
    arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; slowRead = 1'b0;
    void'($urandom(7));
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    axRd(OFS_CTRL, 1'b1, 2'b00, CTRL_RESET, d);
    `CHK(refOn, 1'b1)
    runCmd(CMD_CLEAR, 1'b0, 1'b0);
    `CHK(dacCode, CODE_MIN)
    `CHK(inCode, CODE_MIN)
    runCmd(CMD_CLEAR, 1'b1, 1'b0);
    `CHK(dacCode, CODE_MID)
    // Random codes, read back at prompt and slow device speed.
    for (int i = 0; i < 4; i++) begin
      c = 16'($urandom);
      slowRead = i[0];
      axWr(OFS_WDATA, {16'h0, c}, 2'b00);
      runCmd(CMD_WRITE, 1'b1, 1'b0);
      `CHK(inCode, c)
      `CHK(dacCode, CODE_MID)
      runCmd(CMD_READ, 1'b1, 1'b0);
      axRd(OFS_RDATA, 1'b1, 2'b00, {16'h0, c}, d);
      `CHK(dacCode, CODE_MID)
    end
    runCmd(CMD_LOAD, 1'b1, 1'b0);
    `CHK(dacCode, c)
    c = ~c;
    axWr(OFS_WDATA, {16'h0, c}, 2'b00);
    runCmd(CMD_DIRECT, 1'b1, 1'b1);
    `CHK(dacCode, c)
    `CHK(refOn, 1'b0)
    axRd(OFS_CTRL, 1'b1, 2'b00, 32'h0000_0036, d);
    axRd(4'h6, 1'b1, 2'b10, 32'h0, d);
    repeat (4) @(posedge ref_clk);
    closeOut();
  end
endmodule
